/* File: design/pipe_ctrl.sv */
// Five-stage in-order pipeline sequencing, hazard and decode control
`include "pipe_ctrl_defs.svh"
module pipe_ctrl
	import pipe_ctrl_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        arst_n_in,
	input  wire logic [31:0] fetch_instr_in,
	input  wire logic        mem_wait_in,
	input  wire logic [63:0] rs_val_in,
	input  wire logic [63:0] rt_val_in,
	input  wire logic        cp0_cond_in,
	output logic             processor_cycle_clock_out,
	output logic             phase_two_out,
	output logic [63:0]      fetch_pc_out,
	output stage_act_t       act_out,
	output logic             stall_out,
	output logic             trap_check_out,
	output logic [5:0]       shift_amt_out,
	output shift_kind_t      shift_kind_out,
	output logic             macc_out,
	output logic             dmacc_out,
	output logic [4:0]       wb_dest_out,
	output logic             wb_valid_out
);
	// Pipeline registers, one per stage after fetch
	// The fetch stage is the word at pc_r, caught straight into rf_r;
	// a separate fetch register would add a second delay slot
	stage_slot_t rf_r, ex_r, dc_r, wb_r;
	stage_slot_t rf_nxt, ex_nxt, dc_nxt, wb_nxt;
	logic [63:0] pc_r, pc_nxt;
	logic [1:0]  div_r;
	logic        adv_r;
	logic        wait_s1_r, wait_s2_r;
	logic        ex_load_r;
	logic [4:0]  ex_dest_r;
	logic [4:0]  dc_dest_r;
	decode_t     rf_dec;
	logic        phase_two;
	logic        cyc_end;
	logic        load_use;
	logic        stall;
	logic        hold_all;
	logic        br_taken;
	logic        kill_slot;
	logic [63:0] br_target;
	logic [63:0] off_ext;
	logic [5:0]  op, fn;
	logic [4:0]  rt_f, rs_f;

	// External miss wait comes from the memory side, synchronise it
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wait_s1_r <= 1'b0;
			wait_s2_r <= 1'b0;
		end else begin
			wait_s1_r <= mem_wait_in;
			wait_s2_r <= wait_s1_r;
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			div_r <= 2'h0;
		end else begin
			div_r <= div_r + 2'h1;
		end
	end
	// Four core edges per processor cycle, second half is phase two
	assign phase_two                 = (div_r >= `PHASE_SPLIT);
	assign cyc_end                   = (div_r == `CLK_DIV_LAST);
	assign processor_cycle_clock_out = ~phase_two;
	assign phase_two_out             = phase_two;

	// Decode of the register fetch stage instruction
	assign op   = rf_r.instr[31:26];
	assign fn   = rf_r.instr[5:0];
	assign rs_f = rf_r.instr[25:21];
	assign rt_f = rf_r.instr[20:16];
	always_comb begin
		rf_dec = '0;
		rf_dec.dest = rt_f;
		rf_dec.is_branch = (op >= `OP_BEQ && op <= `OP_BGTZ) ||
			(op >= `OP_BRANCH_EQUAL_LIKELY && op <= `OP_BGTZL) ||
			(op == `OP_REGIMM && (rt_f <= `RI_BGEZL ||
			(rt_f >= `RI_BLTZAL && rt_f <= `RI_BGEZALL))) ||
			(op == `OP_COP0 && rs_f == `CP_BC);
		rf_dec.is_likely = (op >= `OP_BRANCH_EQUAL_LIKELY && op <= `OP_BGTZL) ||
			(op == `OP_REGIMM && (rt_f == `RI_BLTZL || rt_f == `RI_BGEZL ||
			rt_f == `RI_BLTZALL || rt_f == `RI_BGEZALL)) ||
			(op == `OP_COP0 && rs_f == `CP_BC && rt_f[1]);
		rf_dec.is_link = (op == `OP_REGIMM && rt_f[4]) || op == `OP_JAL ||
			(op == `OP_SPECIAL && fn == `FN_JALR);
		rf_dec.is_jump = op == `OP_J || op == `OP_JAL ||
			(op == `OP_SPECIAL && (fn == `FN_JR || fn == `FN_JALR));
		rf_dec.is_load = (op >= `OP_LOAD_LO && op <= `OP_LOAD_HI) ||
			op == `OP_LD || op == `OP_LDL || op == `OP_LDR;
		rf_dec.is_trap = (op == `OP_SPECIAL && fn >= `FN_TGE && fn <= `FN_TNE) ||
			(op == `OP_REGIMM && rt_f >= `RI_TGEI && rt_f <= `RI_TNEI);
		rf_dec.is_macc  = (op == `OP_SPECIAL && fn == `FN_MACC);
		rf_dec.is_dmacc = (op == `OP_SPECIAL && fn == `FN_DMACC);
		rf_dec.shift_amt = {1'b0, rf_r.instr[10:6]};
		if (op == `OP_SPECIAL) begin
			case (fn)
				`FN_SLL, `FN_SLLV, `FN_DSLL, `FN_DWORD_SHL_PLUS32: rf_dec.shift_kind = SH_LEFT;
				`FN_SRL, `FN_SRLV, `FN_DSRL, `FN_DSRL32: rf_dec.shift_kind = SH_RIGHT_LOG;
				`FN_SRA, `FN_SRAV, `FN_DSRA, `FN_DSRA32: rf_dec.shift_kind = SH_RIGHT_ARI;
				default: rf_dec.shift_kind = SH_NONE;
			endcase
			rf_dec.shift_var   = (fn == `FN_SLLV || fn == `FN_SRLV || fn == `FN_SRAV);
			rf_dec.shift_dword = (fn >= `FN_DSLL);
			if (fn >= `FN_DWORD_SHL_PLUS32) begin
				rf_dec.shift_amt = {1'b0, rf_r.instr[10:6]} + `SHAMT_PLUS;
			end
			if (rf_dec.shift_var) begin
				rf_dec.shift_amt = rs_val_in[5:0];
			end
		end
		if (rf_dec.is_link) begin
			rf_dec.dest = `LINK_REG;
		end
		if (op == `OP_SPECIAL) begin
			rf_dec.dest = rf_r.instr[15:11];
		end
	end

	always_comb begin
		br_taken = 1'b0;
		case (op)
			`OP_BEQ, `OP_BRANCH_EQUAL_LIKELY: br_taken = (rs_val_in == rt_val_in);
			`OP_BNE, `OP_BNEL: br_taken = (rs_val_in != rt_val_in);
			`OP_BLEZ, `OP_BLEZL: br_taken = rs_val_in[63] || (rs_val_in == 64'h0);
			`OP_BGTZ, `OP_BGTZL: br_taken = !rs_val_in[63] && (rs_val_in != 64'h0);
			`OP_REGIMM: br_taken = rt_f[0] ? !rs_val_in[63] : rs_val_in[63];
			`OP_COP0: br_taken = rt_f[0] ? cp0_cond_in : !cp0_cond_in;
			default: br_taken = 1'b0;
		endcase
		br_taken = br_taken && rf_dec.is_branch && rf_r.valid;
	end
	assign off_ext   = {{46{rf_r.instr[15]}}, rf_r.instr[15:0], 2'h0};
	// The delay slot is being fetched now, so its address is pc_r
	assign br_target = pc_r + off_ext;
	assign kill_slot = rf_r.valid && rf_dec.is_branch && rf_dec.is_likely && !br_taken;

	assign load_use = ex_load_r && ex_r.valid && ex_dest_r != 5'h0 &&
		rf_r.valid && (ex_dest_r == rs_f || ex_dest_r == rt_f);
	assign hold_all = wait_s2_r;
	assign stall    = load_use && !hold_all;
	assign stall_out = load_use || hold_all;

	// Next state of each stage, taken only at the end of a cycle
	always_comb begin
		pc_nxt = pc_r;
		rf_nxt = rf_r;
		ex_nxt = ex_r;
		dc_nxt = dc_r;
		wb_nxt = wb_r;
		if (cyc_end && !hold_all) begin
			wb_nxt = dc_r;
			dc_nxt = ex_r;
			if (stall) begin
				ex_nxt.valid = 1'b0;
			end else begin
				ex_nxt = rf_r;
				rf_nxt.valid = !kill_slot;
				rf_nxt.pc    = pc_r;
				rf_nxt.instr = fetch_instr_in;
				pc_nxt = br_taken ? br_target : pc_r + `PC_STEP;
			end
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pc_r <= `PC_RESET;
			rf_r <= '0;
			ex_r <= '0;
			dc_r <= '0;
			wb_r <= '0;
		end else begin
			pc_r <= pc_nxt;
			rf_r <= rf_nxt;
			ex_r <= ex_nxt;
			dc_r <= dc_nxt;
			wb_r <= wb_nxt;
		end
	end

	// Side information travelling with the execute slot
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ex_load_r       <= 1'b0;
			ex_dest_r       <= 5'h0;
			dc_dest_r       <= 5'h0;
			adv_r           <= 1'b0;
			trap_check_out  <= 1'b0;
			shift_amt_out   <= 6'h0;
			shift_kind_out  <= SH_NONE;
			macc_out        <= 1'b0;
			dmacc_out       <= 1'b0;
			wb_dest_out     <= 5'h0;
		end else begin
			adv_r <= cyc_end && !hold_all;
			if (cyc_end && !hold_all) begin
				ex_load_r      <= !stall && rf_dec.is_load && rf_r.valid;
				ex_dest_r      <= rf_dec.dest;
				trap_check_out <= !stall && rf_dec.is_trap && rf_r.valid;
				shift_amt_out  <= rf_dec.shift_amt;
				shift_kind_out <= stall ? SH_NONE : rf_dec.shift_kind;
				macc_out       <= !stall && rf_dec.is_macc && rf_r.valid;
				dmacc_out      <= !stall && rf_dec.is_dmacc && rf_r.valid;
				// Destination follows its slot through data cache to write back
				dc_dest_r      <= ex_dest_r;
				wb_dest_out    <= dc_dest_r;
			end
		end
	end

	assign fetch_pc_out = pc_r;
	assign wb_valid_out = wb_r.valid;

	// Phase-timed activity strobes of each stage except register fetch, which has none
	always_comb begin
		act_out = '0;
		act_out.icache_addr_decode   = !phase_two;
		act_out.instr_addr_translate = !phase_two;
		act_out.icache_array_access  = phase_two;
		act_out.instr_tag_check      = phase_two;
		act_out.exec_op              = ex_r.valid && !phase_two;
		act_out.data_vaddr_calc      = ex_r.valid && !phase_two;
		act_out.store_align          = ex_r.valid && !phase_two;
		act_out.dcache_addr_access   = ex_r.valid && phase_two;
		act_out.data_addr_translate  = ex_r.valid && phase_two;
		act_out.load_align           = dc_r.valid && !phase_two;
		act_out.data_tag_check       = dc_r.valid && !phase_two;
		act_out.store_data_transfer  = dc_r.valid && !phase_two;
		act_out.reg_write            = wb_r.valid && !phase_two;
		act_out.dcache_write         = wb_r.valid && !phase_two;
	end

	property p_adv_on_boundary;
		@(posedge clk_in) disable iff (!arst_n_in)
		adv_r |-> $past(div_r) == `CLK_DIV_LAST;
	endproperty
	a_adv_on_boundary: assert property (p_adv_on_boundary) else $error("advance off boundary");

	property p_pc_step;
		@(posedge clk_in) disable iff (!arst_n_in)
		(cyc_end && !hold_all && !stall && !br_taken) |=> pc_r == $past(pc_r) + `PC_STEP;
	endproperty
	a_pc_step: assert property (p_pc_step) else $error("pc did not step");

	property p_branch_target;
		@(posedge clk_in) disable iff (!arst_n_in)
		(cyc_end && !hold_all && !stall && br_taken) |=> pc_r == $past(br_target);
	endproperty
	a_branch_target: assert property (p_branch_target) else $error("bad target");

	// Fetched word carries the address it was fetched from
	property p_slot_pc;
		@(posedge clk_in) disable iff (!arst_n_in)
		(cyc_end && !hold_all && !stall) |=> rf_r.pc == $past(pc_r);
	endproperty
	a_slot_pc: assert property (p_slot_pc) else $error("fetch pc lost");

	property p_likely_kill;
		@(posedge clk_in) disable iff (!arst_n_in)
		(cyc_end && !hold_all && !stall && kill_slot) |=> !rf_r.valid;
	endproperty
	a_likely_kill: assert property (p_likely_kill) else $error("slot not nullified");

	property p_stall_bubble;
		@(posedge clk_in) disable iff (!arst_n_in)
		(cyc_end && stall) |=> !ex_r.valid && $stable(rf_r) && $stable(pc_r);
	endproperty
	a_stall_bubble: assert property (p_stall_bubble) else $error("stall not held");

	property p_load_use;
		@(posedge clk_in) disable iff (!arst_n_in)
		(cyc_end && load_use && !hold_all) |=> !ex_load_r || !ex_r.valid;
	endproperty
	a_load_use: assert property (p_load_use) else $error("load use not stalled");

	property p_miss_hold;
		@(posedge clk_in) disable iff (!arst_n_in)
		(cyc_end && hold_all) |=> $stable(wb_r) && $stable(pc_r);
	endproperty
	a_miss_hold: assert property (p_miss_hold) else $error("miss did not hold");

	property p_wb_phase;
		@(posedge clk_in) disable iff (!arst_n_in)
		act_out.reg_write |-> !phase_two && wb_r.valid;
	endproperty
	a_wb_phase: assert property (p_wb_phase) else $error("write in phase two");

	property p_ex_phases;
		@(posedge clk_in) disable iff (!arst_n_in)
		(act_out.exec_op && div_r == 2'h0) |=> act_out.exec_op ##1 act_out.dcache_addr_access;
	endproperty
	a_ex_phases: assert property (p_ex_phases) else $error("execute phases wrong");
endmodule : pipe_ctrl

/* File: design/pipe_ctrl_defs.svh */
// Constants for the five-stage pipeline control block
`ifndef PIPE_CTRL_DEFS_SVH
`define PIPE_CTRL_DEFS_SVH
`define CLK_DIV_LAST   2'h3
`define PHASE_SPLIT    2'h2
`define OP_SPECIAL     6'h00
`define OP_REGIMM      6'h01
`define OP_J           6'h02
`define OP_JAL         6'h03
`define OP_BEQ         6'h04
`define OP_BNE         6'h05
`define OP_BLEZ        6'h06
`define OP_BGTZ        6'h07
`define OP_COP0        6'h10
`define OP_BRANCH_EQUAL_LIKELY        6'h14
`define OP_BNEL        6'h15
`define OP_BLEZL       6'h16
`define OP_BGTZL       6'h17
`define OP_LOAD_LO     6'h20
`define OP_LOAD_HI     6'h27
`define OP_LDL         6'h1A
`define OP_LDR         6'h1B
`define OP_LD          6'h37
`define FN_SLL         6'h00
`define FN_SRL         6'h02
`define FN_SRA         6'h03
`define FN_SLLV        6'h04
`define FN_SRLV        6'h06
`define FN_SRAV        6'h07
`define FN_JR          6'h08
`define FN_JALR        6'h09
`define FN_MACC        6'h28
`define FN_DMACC       6'h29
`define FN_TGE         6'h30
`define FN_TNE         6'h36
`define FN_DSLL        6'h38
`define FN_DSRL        6'h3A
`define FN_DSRA        6'h3B
`define FN_DWORD_SHL_PLUS32      6'h3C
`define FN_DSRL32      6'h3E
`define FN_DSRA32      6'h3F
`define RI_BLTZ        5'h00
`define RI_BGEZ        5'h01
`define RI_BLTZL       5'h02
`define RI_BGEZL       5'h03
`define RI_TGEI        5'h08
`define RI_TNEI        5'h0E
`define RI_BLTZAL      5'h10
`define RI_BGEZAL      5'h11
`define RI_BLTZALL     5'h12
`define RI_BGEZALL     5'h13
`define CP_BC          5'h08
`define SHAMT_PLUS     6'h20
`define LINK_REG       5'h1F
`define PC_STEP        64'h0000000000000004
`define PC_RESET       64'h0000000000000000
`endif

/* File: design/pipe_ctrl_pkg.sv */
// Types shared by the pipeline control block
package pipe_ctrl_pkg;
	typedef enum logic [2:0] {
		SH_NONE,
		SH_LEFT,
		SH_RIGHT_LOG,
		SH_RIGHT_ARI
	} shift_kind_t;
	typedef struct packed {
		logic        valid;
		logic [63:0] pc;
		logic [31:0] instr;
	} stage_slot_t;
	typedef struct packed {
		logic        is_branch;
		logic        is_likely;
		logic        is_link;
		logic        is_jump;
		logic        is_load;
		logic        is_trap;
		logic        is_macc;
		logic        is_dmacc;
		shift_kind_t shift_kind;
		logic        shift_dword;
		logic        shift_var;
		logic [5:0]  shift_amt;
		logic [4:0]  dest;
	} decode_t;
	typedef struct packed {
		logic icache_addr_decode;
		logic instr_addr_translate;
		logic icache_array_access;
		logic instr_tag_check;
		logic exec_op;
		logic data_vaddr_calc;
		logic store_align;
		logic dcache_addr_access;
		logic data_addr_translate;
		logic load_align;
		logic data_tag_check;
		logic store_data_transfer;
		logic reg_write;
		logic dcache_write;
	} stage_act_t;
endpackage : pipe_ctrl_pkg

/* File: tb/pipe_ctrl_bench.sv */
// Self-checking bench for the five-stage pipeline control block
`include "pipe_ctrl_defs.svh"
`define CHK(nm, exp, got) begin \
	cmp_count++; \
	if ((got) !== (exp)) begin \
		bad_count++; \
		$display("MISMATCH %s expected %0h seen %0h", nm, exp, got); \
	end \
end
module pipe_ctrl_bench
	import pipe_ctrl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic [31:0] instr = 32'h00000000;
	logic        mem_wait = 1'b0;
	logic        cp0 = 1'b0;
	logic [63:0] rs_val = 64'h0;
	logic [63:0] rt_val = 64'h0;
	logic        pcc;
	logic        ph2;
	logic [63:0] pc;
	stage_act_t  act;
	logic        stall;
	logic        trap;
	logic [5:0]  amt;
	shift_kind_t kind;
	logic        macc;
	logic        dmacc;
	logic [4:0]  wb_dest;
	logic        wb_valid;
	int          bad_count = 0;
	int          cmp_count = 0;

	pipe_ctrl i_dut (.clk_in(clk), .arst_n_in(arst_n), .fetch_instr_in(instr),
		.mem_wait_in(mem_wait), .rs_val_in(rs_val), .rt_val_in(rt_val),
		.cp0_cond_in(cp0), .processor_cycle_clock_out(pcc), .phase_two_out(ph2),
		.fetch_pc_out(pc), .act_out(act), .stall_out(stall), .trap_check_out(trap),
		.shift_amt_out(amt), .shift_kind_out(kind), .macc_out(macc),
		.dmacc_out(dmacc), .wb_dest_out(wb_dest), .wb_valid_out(wb_valid));

	// 200 MHz core clock
	always #2.5 clk = ~clk;

	function automatic logic [31:0] rtype(input logic [4:0] rs, rt, rd, sa,
		input logic [5:0] fn);
		return {`OP_SPECIAL, rs, rt, rd, sa, fn};
	endfunction : rtype

	// One processor cycle: inputs change at the falling edge where the divider is 0
	task automatic step(input logic [31:0] ins, input logic [63:0] a, input logic [63:0] b);
		instr = ins;
		rs_val = a;
		rt_val = b;
		repeat (4) @(posedge clk);
		@(negedge clk);
	endtask : step

	task automatic nops(input int n);
		repeat (n) step(32'h00000000, 64'h0, 64'h0);
	endtask : nops

	// phase timing of strobes; checked on a filled pipe
	task automatic t_phase();
		for (int k = 0; k < 4; k++) begin
			`CHK("cycle clock", k < 2, pcc)
			`CHK("phase two", k >= 2, ph2)
			`CHK("icache decode", k < 2, act.icache_addr_decode)
			`CHK("icache array", k >= 2, act.icache_array_access)
			`CHK("vaddr calc", k < 2, act.data_vaddr_calc)
			`CHK("dcache access", k >= 2, act.dcache_addr_access)
			`CHK("load align", k < 2, act.load_align)
			`CHK("reg write", k < 2, act.reg_write)
			@(posedge clk);
			@(negedge clk);
		end
	endtask : t_phase

	// result reaches write back after four cycles
	task automatic t_seq();
		logic [63:0] p;
		p = pc;
		step(rtype(5'h01, 5'h02, 5'h05, 5'h00, 6'h20), 64'h0, 64'h0);
		`CHK("pc step", p + 64'h4, pc)
		nops(3);
		`CHK("wb valid", 1'b1, wb_valid)
		`CHK("wb dest", 5'h05, wb_dest)
		`CHK("pc after four", p + 64'h10, pc)
	endtask : t_seq

	// branch with its delay slot, likely kill on fall-through
	task automatic t_branch(input logic [5:0] op, input logic eq, input logic [15:0] off,
		input logic taken, input logic slot_live);
		logic [63:0] p;
		logic [63:0] tgt;
		p = pc;
		tgt = taken ? p + 64'h4 + {{46{off[15]}}, off, 2'b00} : p + 64'h8;
		step({op, 5'h01, 5'h02, off}, 64'h0, 64'h0);
		step(rtype(5'h00, 5'h00, 5'h07, 5'h00, 6'h20), 64'h5, eq ? 64'h5 : 64'h6);
		`CHK("branch pc", tgt, pc)
		nops(3);
		`CHK("slot valid", slot_live, wb_valid)
		if (slot_live) begin
			`CHK("slot dest", 5'h07, wb_dest)
		end
	endtask : t_branch

	// load-use stall, bubble and held front end
	task automatic t_load();
		logic [63:0] p;
		step({6'h23, 5'h00, 5'h03, 16'h0000}, 64'h0, 64'h0);
		step(rtype(5'h03, 5'h00, 5'h04, 5'h00, 6'h20), 64'h0, 64'h0);
		`CHK("stall", 1'b1, stall)
		p = pc;
		nops(1);
		`CHK("pc held", p, pc)
		`CHK("stall gone", 1'b0, stall)
		nops(1);
		`CHK("load wb", 5'h03, wb_dest)
		nops(1);
		`CHK("bubble", 1'b0, wb_valid)
		nops(1);
		`CHK("user wb", 5'h04, wb_dest)
		`CHK("user valid", 1'b1, wb_valid)
		step({6'h23, 5'h00, 5'h03, 16'h0000}, 64'h0, 64'h0);
		nops(1);
		step(rtype(5'h03, 5'h00, 5'h04, 5'h00, 6'h20), 64'h0, 64'h0);
		`CHK("no stall", 1'b0, stall)
		nops(4);
	endtask : t_load

	task automatic t_decode();
		logic [5:0]  fns [6] = '{`FN_DWORD_SHL_PLUS32, `FN_DSRL32, `FN_DSRA32, `FN_SLL, `FN_MACC,
			`FN_DMACC};
		logic [4:0]  sas [6] = '{5'h05, 5'h00, 5'h1F, 5'h05, 5'h00, 5'h00};
		logic [5:0]  amts [4] = '{6'h25, 6'h20, 6'h3F, 6'h05};
		shift_kind_t kinds [4] = '{SH_LEFT, SH_RIGHT_LOG, SH_RIGHT_ARI, SH_LEFT};
		for (int k = 0; k < 6; k++) begin
			step(rtype(5'h01, 5'h02, 5'h08, sas[k], fns[k]), 64'h0, 64'h0);
			nops(1);
			if (k < 4) begin
				`CHK("shift amount", amts[k], amt)
				`CHK("shift kind", kinds[k], kind)
			end
			`CHK("macc", k == 4, macc)
			`CHK("dmacc", k == 5, dmacc)
		end
	endtask : t_decode

	task automatic t_cop();
		logic [63:0] p;
		p = pc;
		cp0 = 1'b1;
		step({`OP_COP0, `CP_BC, 5'h01, 16'h0004}, 64'h0, 64'h0);
		step(rtype(5'h00, 5'h00, 5'h07, 5'h00, 6'h20), 64'h0, 64'h0);
		`CHK("cop taken pc", p + 64'h14, pc)
		p = pc;
		step({`OP_COP0, `CP_BC, 5'h02, 16'h0004}, 64'h0, 64'h0);
		step(rtype(5'h00, 5'h00, 5'h07, 5'h00, 6'h20), 64'h0, 64'h0);
		`CHK("cop likely pc", p + 64'h8, pc)
		nops(3);
		`CHK("cop slot killed", 1'b0, wb_valid)
		cp0 = 1'b0;
		step(rtype(5'h01, 5'h02, 5'h00, 5'h00, `FN_TGE), 64'h0, 64'h0);
		nops(1);
		`CHK("trap reg", 1'b1, trap)
		step({`OP_REGIMM, 5'h01, `RI_TGEI, 16'h0000}, 64'h0, 64'h0);
		nops(1);
		`CHK("trap imm", 1'b1, trap)
		nops(1);
		`CHK("trap clear", 1'b0, trap)
	endtask : t_cop

	task automatic t_wait();
		logic [63:0] p;
		mem_wait = 1'b1;
		nops(2);
		p = pc;
		nops(2);
		`CHK("pc frozen", p, pc)
		`CHK("miss stall", 1'b1, stall)
		mem_wait = 1'b0;
		nops(3);
		`CHK("pc moves", 1'b1, pc !== p)
	endtask : t_wait

	task automatic complete_run();
		$display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : complete_run

	// Main sequence; reset released at a falling edge so the divider starts clean
	initial begin
		repeat (16) @(posedge clk);
		@(negedge clk);
		arst_n = 1'b1;
		`CHK("reset pc", 64'h0, pc)
		nops(5);
		t_phase();
		t_seq();
		t_branch(`OP_BEQ, 1'b1, 16'h0004, 1'b1, 1'b1);
		t_branch(`OP_BEQ, 1'b0, 16'h0004, 1'b0, 1'b1);
		t_branch(`OP_BEQ, 1'b1, 16'hFFFF, 1'b1, 1'b1);
		t_branch(`OP_BNE, 1'b0, 16'h0002, 1'b1, 1'b1);
		t_branch(`OP_BRANCH_EQUAL_LIKELY, 1'b0, 16'h0004, 1'b0, 1'b0);
		t_branch(`OP_BRANCH_EQUAL_LIKELY, 1'b1, 16'h0004, 1'b1, 1'b1);
		t_branch(`OP_BNEL, 1'b1, 16'h0004, 1'b0, 1'b0);
		t_load();
		t_cop();
		t_decode();
		t_wait();
		complete_run();
	end

	// Watchdog well beyond the fewer than one hundred processor cycles the tests need
	initial begin
		#20000;
		bad_count++;
		complete_run();
	end
endmodule : pipe_ctrl_bench
